// [pkg/tdc_pkg.sv]
// shared constants and carriers of the multi-hit time-to-digital acquisition block
package tdc_pkg;

    // =====================================================================
    // structure
    localparam int NCH       = 96;
    localparam int HIT_DEPTH = 16;
    localparam int NEV       = 16;
    localparam int EV_WORDS  = 2048;

    // =====================================================================
    // timing
    localparam int CLK_PS        = 25000;
    localparam int LSB_PS        = 500;
    localparam int LSB_HALF_PS   = 1000;
    localparam int RANGE_NS      = 32768;
    localparam int FCW_MIN_NS    = 800;
    localparam int READY_NS      = 500;
    localparam int HIT_SEP_NS    = 10;
    localparam logic [15:0] STEP_FULL = 16'(CLK_PS / LSB_PS);
    localparam logic [15:0] STEP_HALF = 16'(CLK_PS / LSB_HALF_PS);
    localparam int ACQ_MAX_CYC   = (RANGE_NS * 1000) / CLK_PS;
    localparam int FCW_MIN_CYC   = (FCW_MIN_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int READY_CYC     = (READY_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int HIT_SEP_CYC   = (HIT_SEP_NS * 1000 + CLK_PS - 1) / CLK_PS;

    // =====================================================================
    // reset values
    localparam logic [15:0] FINE_RST = 16'h0000;
    localparam logic [10:0] WCNT_RST = 11'h001;

    // =====================================================================
    // carriers
    typedef struct packed {
        logic [4:0]  geo;
        logic [1:0]  bufn;
        logic        parity;
        logic        phase;
        logic [6:0]  chan;
        logic [15:0] tval;
    } hit_word_t;

    typedef struct packed {
        logic [4:0]  geo;
        logic [1:0]  bufn;
        logic        parity;
        logic [12:0] zero;
        logic [10:0] count;
    } hdr_word_t;

    typedef struct packed {
        logic        phase;
        logic [15:0] stamp;
    } hit_entry_t;

    typedef enum {ST_PROG, ST_ARMED, ST_WINDOW, ST_FCW, ST_XFER} acq_state_t;

endpackage

// [rtl/hit_lifo.sv]
// per-channel last-in-first-out hit store keeping the most recent entries
`timescale 1ns/1ps
`default_nettype none
module hit_lifo #(
    parameter int DEPTH = 16,
    parameter int DW    = 17,
    parameter int CW    = $clog2(DEPTH + 1)
) (
    // clock and reset
    input  wire logic          clk_in,
    input  wire logic          rst_n_in,
    // control
    input  wire logic          clear_in,
    input  wire logic          push_in,
    input  wire logic          pop_in,
    input  wire logic [CW-1:0] limit_in,
    // data
    input  wire logic [DW-1:0] data_in,
    output logic      [DW-1:0] data_out,
    output logic      [CW-1:0] count_out
);
    localparam int AW = $clog2(DEPTH);
    logic [DW-1:0] mem_r [DEPTH];
    logic [AW-1:0] wp_r;
    logic [CW-1:0] count_r;
    logic [CW-1:0] limit;

    assign limit     = (limit_in == '0 || limit_in > CW'(DEPTH)) ? CW'(DEPTH) : limit_in;
    assign data_out  = mem_r[wp_r - AW'(1)];
    assign count_out = count_r;

    always_ff @(posedge clk_in) begin
        if (push_in) begin
            mem_r[wp_r] <= data_in;
        end
    end

    // older entries beyond the limit are simply dropped from the count
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wp_r    <= '0;
            count_r <= '0;
        end else if (clear_in) begin
            wp_r    <= '0;
            count_r <= '0;
        end else if (push_in) begin
            wp_r    <= wp_r + AW'(1);
            count_r <= (count_r >= limit) ? limit : count_r + CW'(1);
        end else if (pop_in && count_r != '0) begin
            wp_r    <= wp_r - AW'(1);
            count_r <= count_r - CW'(1);
        end
    end

    AST_LIFO_LIMIT: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        push_in && !clear_in |=> count_r <= limit && count_r != '0)
        else $error("hit store count above its programmed limit");

endmodule
`default_nettype wire

// [rtl/tdc_acq.sv]
// acquisition, fast-clear window, event buffering and readout of the 96-channel converter
`timescale 1ns/1ps
`default_nettype none
module tdc_acq #(
    parameter int NCH   = tdc_pkg::NCH,
    parameter int DEPTH = tdc_pkg::HIT_DEPTH,
    parameter int NEV   = tdc_pkg::NEV,
    parameter int EVW   = tdc_pkg::EV_WORDS,
    parameter int CHW   = $clog2(NCH),
    parameter int CW    = $clog2(DEPTH + 1),
    parameter int EW    = $clog2(NEV),
    parameter int WW    = $clog2(EVW)
) (
    // clock and reset
    input  wire logic             MCLK_IN,
    input  wire logic             RSTN_IN,
    // configuration
    input  wire logic             CFG_DONE_IN,
    input  wire logic             COMMON_STOP_IN,
    input  wire logic             CLK_HALF_IN,
    input  wire logic             EXT_TIMEOUT_SEL_IN,
    input  wire logic [11:0]      TIMEOUT_CYC_IN,
    input  wire logic [13:0]      FCW_CYC_IN,
    input  wire logic [CW-1:0]    HITS_MAX_IN,
    input  wire logic [2*NCH-1:0] EDGE_SEL_IN,
    input  wire logic [4:0]       GEO_ADDR_IN,
    // front inputs
    input  wire logic [NCH-1:0]   HIT_IN,
    input  wire logic             COMMON_IN,
    input  wire logic             TIMEOUT_IN,
    input  wire logic             CLEAR_IN,
    // readout
    input  wire logic             RD_STROBE_IN,
    output logic      [31:0]      RD_DATA_OUT,
    output logic                  RD_VALID_OUT,
    output logic                  RD_LAST_OUT,
    // status
    output logic                  ACQ_ACTIVE_OUT,
    output logic                  FCW_OPEN_OUT,
    output logic                  XFER_BUSY_OUT,
    output logic      [EW:0]      EVENTS_OUT,
    output logic                  READY_OUT,
    output logic                  FULL_OUT
);
    localparam int RDY_D = tdc_pkg::READY_CYC;

    tdc_pkg::acq_state_t state_r;
    tdc_pkg::acq_state_t state_nxt;

    logic [15:0]  fine_r;
    logic [15:0]  ref_ts_r;
    logic [NCH-1:0] hit_prev_r;
    logic         com_prev_r;
    logic         com_rise;
    logic [11:0]  win_cnt_r;
    logic [13:0]  fcw_cnt_r;
    logic [13:0]  fcw_len;
    logic         record_en;
    logic         win_end;
    logic [NCH-1:0] push_vec;
    logic [NCH-1:0] pop_vec;
    logic [16:0]  lifo_data [NCH];
    logic [CW-1:0] lifo_cnt [NCH];
    logic [CHW-1:0] ch_r;
    logic [WW-1:0] wcnt_r;
    logic [EW-1:0] wr_ev_r;
    logic [EW-1:0] rd_ev_r;
    logic [WW-1:0] rd_idx_r;
    logic [EW:0]  used_r;
    logic [EW:0]  avail_r;
    logic [5:0]   rdy_cnt_r;
    logic         commit;
    logic         rel;
    logic         retire;
    logic         fast_clear;
    logic         sel_more;
    logic         mem_we;
    logic [EW+WW-1:0] mem_wa;
    logic [31:0]  mem_wd;
    logic [31:0]  ev_mem_r [NEV*EVW];
    logic [WW-1:0] wc_mem_r [NEV];
    tdc_pkg::hit_entry_t sel_ent;
    tdc_pkg::hit_word_t  hw;
    tdc_pkg::hdr_word_t  hd;

    // =====================================================================
    // time base and input edges
    always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            fine_r <= tdc_pkg::FINE_RST;
        end else begin
            fine_r <= fine_r + (CLK_HALF_IN ? tdc_pkg::STEP_HALF : tdc_pkg::STEP_FULL);
        end
    end

    // one sample per clock: edges at least one clock apart are kept apart
    always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            hit_prev_r <= '0;
            com_prev_r <= 1'b0;
        end else begin
            hit_prev_r <= HIT_IN;
            com_prev_r <= COMMON_IN;
        end
    end

    assign com_rise  = COMMON_IN && !com_prev_r;
    assign record_en = (state_r == tdc_pkg::ST_WINDOW) ||
                       (state_r == tdc_pkg::ST_ARMED && COMMON_STOP_IN);

    // =====================================================================
    // per-channel hit stores
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            logic rise;
            logic fall;
            assign rise = HIT_IN[g] && !hit_prev_r[g];
            assign fall = !HIT_IN[g] && hit_prev_r[g];
            assign push_vec[g] = record_en &&
                ((rise && EDGE_SEL_IN[2*g]) || (fall && EDGE_SEL_IN[2*g+1]));
            assign pop_vec[g]  = (state_r == tdc_pkg::ST_XFER) && (ch_r == CHW'(g));
            hit_lifo #(.DEPTH(DEPTH), .DW(17)) u_lifo (
                .clk_in    (MCLK_IN),
                .rst_n_in  (RSTN_IN),
                .clear_in  (fast_clear),
                .push_in   (push_vec[g]),
                .pop_in    (pop_vec[g]),
                .limit_in  (HITS_MAX_IN),
                .data_in   ({fall, fine_r}),
                .data_out  (lifo_data[g]),
                .count_out (lifo_cnt[g])
            );
        end
    endgenerate

    // =====================================================================
    // acquisition sequencing
    assign fcw_len    = (FCW_CYC_IN < 14'(tdc_pkg::FCW_MIN_CYC)) ?
                        14'(tdc_pkg::FCW_MIN_CYC) : FCW_CYC_IN;
    assign fast_clear = (state_r == tdc_pkg::ST_FCW) && CLEAR_IN;
    assign win_end    = (!EXT_TIMEOUT_SEL_IN && win_cnt_r + 12'h001 >= TIMEOUT_CYC_IN) ||
                        (EXT_TIMEOUT_SEL_IN && TIMEOUT_IN) ||
                        (win_cnt_r == 12'(tdc_pkg::ACQ_MAX_CYC - 1));
    assign sel_ent    = lifo_data[ch_r];
    assign sel_more   = lifo_cnt[ch_r] != '0;
    assign commit     = (state_r == tdc_pkg::ST_XFER) && !sel_more && (ch_r == CHW'(NCH - 1));

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            tdc_pkg::ST_PROG: begin
                if (CFG_DONE_IN) begin
                    state_nxt = tdc_pkg::ST_ARMED;
                end
            end
            tdc_pkg::ST_ARMED: begin
                if (com_rise) begin
                    state_nxt = COMMON_STOP_IN ? tdc_pkg::ST_FCW : tdc_pkg::ST_WINDOW;
                end
            end
            tdc_pkg::ST_WINDOW: begin
                if (win_end) begin
                    state_nxt = tdc_pkg::ST_FCW;
                end
            end
            tdc_pkg::ST_FCW: begin
                if (CLEAR_IN) begin
                    state_nxt = tdc_pkg::ST_ARMED;
                end else if (fcw_cnt_r + 14'h0001 >= fcw_len && used_r != (EW+1)'(NEV)) begin
                    state_nxt = tdc_pkg::ST_XFER;
                end
            end
            tdc_pkg::ST_XFER: begin
                if (commit) begin
                    state_nxt = tdc_pkg::ST_ARMED;
                end
            end
            default: state_nxt = tdc_pkg::ST_PROG;
        endcase
    end

    always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            state_r <= tdc_pkg::ST_PROG;
        end else begin
            state_r <= state_nxt;
        end
    end

    // later common pulses fall outside the armed state and are dropped
    always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            ref_ts_r <= tdc_pkg::FINE_RST;
        end else if (state_r == tdc_pkg::ST_ARMED && com_rise) begin
            ref_ts_r <= fine_r;
        end
    end

    always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            win_cnt_r <= '0;
            fcw_cnt_r <= '0;
        end else begin
            win_cnt_r <= (state_r == tdc_pkg::ST_WINDOW) ? win_cnt_r + 12'h001 : 12'h000;
            fcw_cnt_r <= (state_r == tdc_pkg::ST_FCW) ? fcw_cnt_r + 14'h0001 : 14'h0000;
        end
    end

    // =====================================================================
    // transfer into the circular event buffer
    always_comb begin
        hw        = '0;
        hw.geo    = GEO_ADDR_IN;
        hw.bufn   = wr_ev_r[1:0];
        hw.phase  = sel_ent.phase;
        hw.chan   = 7'(ch_r);
        hw.tval   = COMMON_STOP_IN ? ref_ts_r - sel_ent.stamp : sel_ent.stamp - ref_ts_r;
        hw.parity = ^hw;
        hd        = '0;
        hd.geo    = GEO_ADDR_IN;
        hd.bufn   = wr_ev_r[1:0];
        hd.count  = wcnt_r;
        hd.parity = ^hd;
    end

    assign mem_we = (state_r == tdc_pkg::ST_XFER) && (sel_more || commit);
    assign mem_wa = {wr_ev_r, sel_more ? wcnt_r : WW'(0)};
    assign mem_wd = sel_more ? 32'(hw) : 32'(hd);

    always_ff @(posedge MCLK_IN) begin
        if (mem_we) begin
            ev_mem_r[mem_wa] <= mem_wd;
        end
        if (commit) begin
            wc_mem_r[wr_ev_r] <= wcnt_r;
        end
    end

    always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            ch_r    <= '0;
            wcnt_r  <= tdc_pkg::WCNT_RST;
            wr_ev_r <= '0;
        end else if (state_r != tdc_pkg::ST_XFER) begin
            ch_r   <= '0;
            wcnt_r <= tdc_pkg::WCNT_RST;
        end else if (sel_more) begin
            wcnt_r <= wcnt_r + WW'(1);
        end else if (commit) begin
            wr_ev_r <= wr_ev_r + EW'(1);
        end else begin
            ch_r <= ch_r + CHW'(1);
        end
    end

    // =====================================================================
    // release delay and event accounting
    assign rel    = (rdy_cnt_r == 6'h01);
    assign retire = RD_STROBE_IN && avail_r != '0 && (rd_idx_r + WW'(1) == wc_mem_r[rd_ev_r]);

    always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            rdy_cnt_r <= '0;
        end else if (commit) begin
            rdy_cnt_r <= 6'(tdc_pkg::READY_CYC);
        end else if (rdy_cnt_r != '0) begin
            rdy_cnt_r <= rdy_cnt_r - 6'h01;
        end
    end

    always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            used_r  <= '0;
            avail_r <= '0;
        end else begin
            used_r  <= used_r + (EW+1)'(commit) - (EW+1)'(retire);
            avail_r <= avail_r + (EW+1)'(rel) - (EW+1)'(retire);
        end
    end

    // =====================================================================
    // readout, independent of the acquisition sequencer
    always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            rd_ev_r      <= '0;
            rd_idx_r     <= '0;
            RD_DATA_OUT  <= '0;
            RD_VALID_OUT <= 1'b0;
            RD_LAST_OUT  <= 1'b0;
        end else begin
            RD_VALID_OUT <= RD_STROBE_IN && avail_r != '0;
            RD_LAST_OUT  <= retire;
            if (RD_STROBE_IN && avail_r != '0) begin
                RD_DATA_OUT <= ev_mem_r[{rd_ev_r, rd_idx_r}];
                rd_idx_r    <= retire ? WW'(0) : rd_idx_r + WW'(1);
                rd_ev_r     <= retire ? rd_ev_r + EW'(1) : rd_ev_r;
            end
        end
    end

    assign ACQ_ACTIVE_OUT = record_en;
    assign FCW_OPEN_OUT   = (state_r == tdc_pkg::ST_FCW);
    assign XFER_BUSY_OUT  = (state_r == tdc_pkg::ST_XFER);
    assign EVENTS_OUT     = used_r;
    assign READY_OUT      = avail_r != '0;
    assign FULL_OUT       = used_r == (EW+1)'(NEV);

    // =====================================================================
    // checks
    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (!RSTN_IN);

    sequence s_commit;
        commit;
    endsequence
    sequence s_release;
        rel && !commit;
    endsequence

    AST_PROG_HOLD: assert property (state_r == tdc_pkg::ST_PROG && !CFG_DONE_IN |=>
        state_r == tdc_pkg::ST_PROG) else $error("left programming without configuration");
    AST_WINDOW_CAP: assert property (state_r == tdc_pkg::ST_WINDOW |->
        win_cnt_r < 12'(tdc_pkg::ACQ_MAX_CYC)) else $error("acquisition window overran its limit");
    AST_FIRST_COMMON: assert property (state_r == tdc_pkg::ST_WINDOW && com_rise |=>
        $stable(ref_ts_r)) else $error("later common pulse moved the reference");
    AST_NO_REC_XFER: assert property (state_r == tdc_pkg::ST_XFER |->
        push_vec == '0 && !record_en) else $error("hit recorded during transfer");
    AST_READY_DELAY: assert property (s_commit |-> ##RDY_D s_release)
        else $error("event not released after the ready delay");
    AST_FCW_MIN: assert property (state_r == tdc_pkg::ST_FCW && state_nxt == tdc_pkg::ST_XFER |->
        fcw_cnt_r >= 14'(tdc_pkg::FCW_MIN_CYC - 1)) else $error("fast-clear window too short");
    AST_FULL_STALL: assert property (state_r == tdc_pkg::ST_FCW && FULL_OUT |=>
        state_r != tdc_pkg::ST_XFER) else $error("transfer started into a full buffer");
    AST_RETURN_ACQ: assert property (s_commit |=> state_r == tdc_pkg::ST_ARMED ##1
        state_r != tdc_pkg::ST_XFER) else $error("no return to acquisition after buffering");
    AST_READ_WHILE_ACQ: assert property (RD_STROBE_IN && READY_OUT |=> RD_VALID_OUT)
        else $error("readout refused while data was ready");

endmodule
`default_nettype wire

// [verification/front_model.sv]
// far-side model: discriminator outputs and readout host of the converter
`timescale 1ns/1ps
`default_nettype none
module front_model (
    // clock
    input  wire logic        clk_in,
    // discriminator side
    output logic [95:0]      hit_out,
    output logic             common_out,
    output logic             timeout_out,
    output logic             clear_out,
    // readout host side
    output logic             strobe_out,
    input  wire logic [31:0] data_in,
    input  wire logic        valid_in,
    input  wire logic        last_in
);
    initial begin
        hit_out     = '0;
        common_out  = 1'h0;
        timeout_out = 1'h0;
        clear_out   = 1'h0;
        strobe_out  = 1'h0;
    end
    // one cycle of front lines; ch below zero leaves every channel still
    task automatic step(input logic com, input logic tim, input logic clr, input int ch);
        @(posedge clk_in);
        common_out  <= com;
        timeout_out <= tim;
        clear_out   <= clr;
        if (ch >= 0)
            hit_out[ch] <= ~hit_out[ch];
    endtask
    // one word read: strobe one cycle, answer looked at in the following cycle
    task automatic read(output logic [31:0] d, output logic v, output logic l);
        @(posedge clk_in);
        strobe_out <= 1'h1;
        @(posedge clk_in);
        strobe_out <= 1'h0;
        @(negedge clk_in);
        d = data_in;
        v = valid_in;
        l = last_in;
    endtask
endmodule
`default_nettype wire

// [verification/multi_hit_tdc_acquisition_bench.sv]
// self-checking bench of the acquisition block with random events
`timescale 1ns/1ps
`default_nettype none
module multi_hit_tdc_acquisition_bench;
    // ==========================================================
    // signals
    logic        mclk, rst_n, cfg_done, c_stop, c_half, ext_sel;
    logic [11:0] tmo_cyc;
    logic [13:0] fcw_cyc;
    logic [4:0]  hits_max, geo;
    logic [191:0] edge_sel;
    logic [95:0] hit;
    logic        common, tmo, clr, strobe, rd_valid, rd_last;
    logic        acq, fcw_open, xfer_busy, ready, full;
    logic [31:0] rd_data;
    logic [4:0]  events;
    int          seed, error_cnt, compares, acq_cnt, nexp, nbuf;
    logic [31:0] exp_q[$];
    int          cnt_q[$];

    tdc_acq tdc_acq_inst (.MCLK_IN(mclk), .RSTN_IN(rst_n), .CFG_DONE_IN(cfg_done),
        .COMMON_STOP_IN(c_stop), .CLK_HALF_IN(c_half), .EXT_TIMEOUT_SEL_IN(ext_sel),
        .TIMEOUT_CYC_IN(tmo_cyc), .FCW_CYC_IN(fcw_cyc), .HITS_MAX_IN(hits_max),
        .EDGE_SEL_IN(edge_sel), .GEO_ADDR_IN(geo), .HIT_IN(hit), .COMMON_IN(common),
        .TIMEOUT_IN(tmo), .CLEAR_IN(clr), .RD_STROBE_IN(strobe), .RD_DATA_OUT(rd_data),
        .RD_VALID_OUT(rd_valid), .RD_LAST_OUT(rd_last), .ACQ_ACTIVE_OUT(acq),
        .FCW_OPEN_OUT(fcw_open), .XFER_BUSY_OUT(xfer_busy), .EVENTS_OUT(events),
        .READY_OUT(ready), .FULL_OUT(full));

    front_model front_model_inst (.clk_in(mclk), .hit_out(hit), .common_out(common),
        .timeout_out(tmo), .clear_out(clr), .strobe_out(strobe), .data_in(rd_data),
        .valid_in(rd_valid), .last_in(rd_last));

    initial begin
        mclk = 1'h0;
        forever #12.5 mclk = ~mclk;
    end
    always @(posedge mclk) if (acq === 1'h1) acq_cnt <= acq_cnt + 1;

    // ==========================================================
    // helpers
    task automatic summarize();
        if (error_cnt == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    function automatic logic cond(input int w);
        case (w)
            0: return fcw_open === 1'h0 && xfer_busy === 1'h0;
            1: return events === 5'(nexp);
            2: return ready === 1'h1;
            default: return fcw_open === 1'h1;
        endcase
    endfunction
    task automatic waitc(input int w, input int lim);
        int i;
        for (i = 0; i < lim && !cond(w); i++) @(posedge mclk);
        if (i == lim) begin
            error_cnt++;
            summarize();
        end
    endtask
    // even parity over the whole word
    function automatic logic [31:0] par(input logic [31:0] w);
        w[24] = ^w;
        return w;
    endfunction

    // ==========================================================
    // one event on a random channel
    task automatic run_event(input logic stop, input logic half, input logic ext,
                             input int k, input logic clear);
        int ch, sel, nt, hm, p, cd, a0, n, d, c;
        int toff[$];
        logic lvl, com, tim;
        logic [15:0] stp;
        logic [31:0] hw[$];
        waitc(0, 4000);
        ch = {$random(seed)} % 96;
        sel = {$random(seed)} % 3 + 1;
        nt = {$random(seed)} % 40 + 1;
        hm = {$random(seed)} % 18;
        @(posedge mclk);
        c_stop <= stop;
        c_half <= half;
        ext_sel <= ext;
        tmo_cyc <= ext ? 12'hFFF : 12'(k);
        hits_max <= 5'(hm);
        fcw_cyc <= 14'({$random(seed)} % 64);
        edge_sel[2*ch +: 2] <= 2'(sel);
        repeat (3) front_model_inst.step(1'h0, 1'h0, 1'h0, -1);
        a0 = acq_cnt;
        lvl = hit[ch];
        stp = half ? tdc_pkg::STEP_HALF : tdc_pkg::STEP_FULL;
        p = stop ? 0 : 2;
        for (int i = 0; i < nt; i++) begin
            toff.push_back(p);
            p += {$random(seed)} % 3 + 1;
        end
        cd = stop ? p + 1 : 0;
        for (int i = 0; i < nt; i++) begin
            lvl = ~lvl;
            if (sel[lvl ? 0 : 1] && (stop || toff[i] <= k))
                hw.push_back(par({geo, 2'(nbuf), 1'h0, ~lvl, 7'(ch),
                    16'(stop ? cd - toff[i] : toff[i]) * stp}));
        end
        n = 0;
        for (d = 0; d <= (stop ? cd + 1 : k + 4); d++) begin
            com = stop ? d == cd : (d == 0 || d == 3);
            tim = ext && d == k && k != tdc_pkg::ACQ_MAX_CYC;
            if (n < nt && toff[n] == d) begin
                front_model_inst.step(com, tim, 1'h0, ch);
                n++;
            end else
                front_model_inst.step(com, tim, 1'h0,
                    ((stop && d == cd + 1) || d == k + 3) ? ch : -1);
        end
        if (!stop)
            check("acq_len", acq_cnt - a0, k);
        if (clear) begin
            waitc(3, 10);
            front_model_inst.step(1'h0, 1'h0, 1'h1, -1);
            front_model_inst.step(1'h0, 1'h0, 1'h0, -1);
            waitc(0, 200);
            check("events_clr", events, nexp);
        end else begin
            c = hw.size() < ((hm >= 1 && hm <= 16) ? hm : 16) ? hw.size()
                : ((hm >= 1 && hm <= 16) ? hm : 16);
            exp_q.push_back(par({geo, 2'(nbuf), 1'h0, 13'h0, 11'(c + 1)}));
            for (int j = hw.size() - 1; j >= hw.size() - c; j--)
                exp_q.push_back(hw[j]);
            cnt_q.push_back(c + 1);
            nexp++;
            nbuf++;
            waitc(1, 3000);
            waitc(2, 40);
        end
    endtask

    task automatic read_all(input int ne);
        logic [31:0] d;
        logic v, l;
        int c;
        repeat (ne) begin
            c = cnt_q.pop_front();
            for (int w = 0; w < c; w++) begin
                front_model_inst.read(d, v, l);
                check("rd_valid", v, 1);
                check("rd_word", d, exp_q.pop_front());
                check("rd_last", l, w == c - 1);
            end
            nexp--;
        end
        front_model_inst.step(1'h0, 1'h0, 1'h0, -1);
        check("events_rd", events, nexp);
    endtask

    // ==========================================================
    // main sequence
    initial begin
        seed = 32'h694365D3;
        {rst_n, cfg_done, c_stop, c_half, ext_sel} = 5'h00;
        tmo_cyc = 12'h0C8;
        fcw_cyc = 14'h0000;
        hits_max = 5'h10;
        geo = 5'($random(seed));
        edge_sel = '0;
        repeat (20) @(posedge mclk);
        rst_n <= 1'h1;
        @(negedge mclk);
        check("events_rst", {ready, full, acq, events}, 0);
        @(posedge mclk);
        cfg_done <= 1'h1;
        for (int i = 0; i < 16; i++)
            run_event(1'($random(seed)), 1'($random(seed)), 1'h0, 200, 1'h0);
        check("full", {full, events}, 6'h30);
        // an event closing on a full buffer holds in the fast-clear window
        @(posedge mclk);
        c_stop <= 1'h0;
        ext_sel <= 1'h0;
        tmo_cyc <= 12'h010;
        front_model_inst.step(1'h1, 1'h0, 1'h0, -1);
        repeat (100) front_model_inst.step(1'h0, 1'h0, 1'h0, -1);
        check("full_stall", {fcw_open, xfer_busy, full}, 3'h5);
        read_all(1);
        exp_q.push_back(par({geo, 2'(nbuf), 1'h0, 13'h0, 11'h001}));
        cnt_q.push_back(1);
        nexp++;
        nbuf++;
        waitc(1, 300);
        read_all(16);
        run_event(1'h0, 1'h0, 1'h1, 60, 1'h0);
        run_event(1'h0, 1'h1, 1'h1, tdc_pkg::ACQ_MAX_CYC, 1'h0);
        run_event(1'h0, 1'h0, 1'h0, 200, 1'h1);
        read_all(2);
        summarize();
    end
    initial begin
        repeat (100000) @(posedge mclk);
        error_cnt++;
        summarize();
    end
endmodule
`default_nettype wire
